// ===== src/program_flash_write_erase_control.v
// Flash write, erase and program sequencer behind the core's special function registers.
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctl_consts.vh"
module program_flash_write_erase_control (
   // Clock and reset
   input  wire        ref_clk_i,
   input  wire        rst_i,
   // Special function register port from the core
   input  wire        sfr_wr_i,
   input  wire        sfr_rd_i,
   input  wire [7:0]  sfr_addr_i,
   input  wire [7:0]  sfr_wdata_i,
   output reg  [7:0]  sfr_rdata_o,
   // External move writes from the core
   input  wire        xmove_wr_i,
   input  wire        xmove_ind_i,
   input  wire [15:0] data_pointer_i,
   input  wire [7:0]  port2_latch_i,
   input  wire [7:0]  index_reg_i,
   input  wire [7:0]  acc_i,
   // Core stall and data-space write path
   output wire        flash_busy_stall_o,
   output reg         data_wr_o,
   output reg  [15:0] data_addr_o,
   output reg  [7:0]  data_wdata_o,
   // Flash macro side
   output reg         flash_preprog_o,
   output reg         flash_erase_o,
   output reg         flash_chip_o,
   output reg         flash_program_o,
   output reg  [15:0] flash_addr_o,
   output wire [15:0] flash_wdata_o,
   output wire [4:0]  flash_clock_mhz_code_o,
   output wire [7:0]  flash_prog_timing_o,
   output wire [7:0]  flash_erase_timing_o,
   input  wire        flash_done_i
);
   // One-hot sequencer states; the macro sees one phase request at a time.
   localparam [3:0] ST_IDLE    = 4'b0001;
   localparam [3:0] ST_PREPROG = 4'b0010;
   localparam [3:0] ST_ERASE   = 4'b0100;
   localparam [3:0] ST_PROGRAM = 4'b1000;

   // Address compare shared by every register write decode; the read-back uses a case.
   function hit;
      input [7:0] a;
      input [7:0] b;
      begin
         hit = (a == b);
      end
   endfunction

   // Register file, key window and sequencer state.
   reg  [7:0]  power_control_reg;
   reg  [5:0]  flash_operation_control_reg;
   reg  [4:0]  flash_clock_frequency_reg;
   reg  [7:0]  flash_program_timing_reg;
   reg  [7:0]  flash_erase_timing_reg;
   reg  [1:0]  key_state_reg;
   reg  [3:0]  state_reg;
   reg  [3:0]  state_next;
   reg         even_held_reg;
   reg  [15:0] even_addr_reg;
   reg         flash_done_meta_reg;
   reg         flash_done_sync_reg;

   // Decodes of the core's accesses.
   wire        program_write_enable = power_control_reg[`PWE_BIT];
   wire        any_access = sfr_wr_i | sfr_rd_i;
   wire        key_write = sfr_wr_i & hit(sfr_addr_i, `ADDR_TIMED_ACCESS_KEY);
   wire        ctrl_write = sfr_wr_i & hit(sfr_addr_i, `ADDR_FLASH_OP_CTRL);
   wire        unlocked = key_state_reg[1];
   wire [15:0] xmove_addr = xmove_ind_i ? {port2_latch_i, index_reg_i}
                                        : data_pointer_i;
   wire        prog_wr = xmove_wr_i & program_write_enable & (state_reg == ST_IDLE);
   // A done strobe counts only while a phase is running.
   wire        op_done = (state_reg != ST_IDLE) & flash_done_sync_reg;
   wire        chip_mode = (flash_operation_control_reg == `OP_CHIP_ERASE);
   wire        word_mode = (flash_operation_control_reg == `OP_WORD_PROGRAM);
   wire        phase_start = (state_reg == ST_IDLE) & (state_next == ST_PREPROG);
   // An odd byte completes a word only against the even byte held just before it.
   wire        odd_pairs = xmove_addr[0] & even_held_reg &
                           (xmove_addr[15:1] == even_addr_reg[15:1]);
   wire        stage_wr = prog_wr & word_mode & (~xmove_addr[0] | odd_pairs);

   // The core stays stalled for the whole busy spell, done latency included.
   assign flash_busy_stall_o     = (state_reg != ST_IDLE);
   assign flash_clock_mhz_code_o = flash_clock_frequency_reg;
   assign flash_prog_timing_o    = flash_program_timing_reg;
   assign flash_erase_timing_o   = flash_erase_timing_reg;

   // The done strobe comes from the flash macro's own timing and is synchronised.
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         flash_done_meta_reg <= 1'b0;
         flash_done_sync_reg <= 1'b0;
      end else begin
         flash_done_meta_reg <= flash_done_i;
         flash_done_sync_reg <= flash_done_meta_reg;
      end
   end

   // Key sequence: bit 0 means first key seen, bit 1 means window open.
   // Any other register access before the control write closes the window.
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         key_state_reg <= 2'b00;
      end else if (key_write) begin
         if (sfr_wdata_i == `KEY_FIRST) begin
            key_state_reg <= 2'b01;
         end else if (sfr_wdata_i == `KEY_SECOND && key_state_reg == 2'b01) begin
            key_state_reg <= 2'b10;
         end else begin
            key_state_reg <= 2'b00;
         end
      end else if (any_access) begin
         key_state_reg <= 2'b00;
      end
   end

   // Power control; only the write enable bit matters to this block.
   // The other bits are kept for software but act elsewhere in the device.
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         power_control_reg <= `RST_POWER_CONTROL;
      end else if (sfr_wr_i && hit(sfr_addr_i, `ADDR_POWER_CONTROL)) begin
         power_control_reg <= sfr_wdata_i;
      end
   end

   // Clock frequency code in whole MHz.
   // Code zero is undefined; software never writes it.
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         flash_clock_frequency_reg <= `RST_FLASH_CLK_FLASH_CLOCK_MHZ_CODE;
      end else if (sfr_wr_i && hit(sfr_addr_i, `ADDR_FLASH_CLK_FLASH_CLOCK_MHZ_CODE)) begin
         flash_clock_frequency_reg <= sfr_wdata_i[`FLASH_CLOCK_MHZ_CODE_MSB:0];
      end
   end

   // Program pulse timing, passed straight to the macro.
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         flash_program_timing_reg <= `RST_FLASH_PROG_TIMING;
      end else if (sfr_wr_i && hit(sfr_addr_i, `ADDR_FLASH_PROG_TIMING)) begin
         flash_program_timing_reg <= sfr_wdata_i;
      end
   end

   // Erase pulse timing, passed straight to the macro.
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         flash_erase_timing_reg <= `RST_FLASH_ERASE_TIMING;
      end else if (sfr_wr_i && hit(sfr_addr_i, `ADDR_FLASH_ERASE_TIMING)) begin
         flash_erase_timing_reg <= sfr_wdata_i;
      end
   end

   // Operation code; completion of an erase wins over a control write in the same cycle.
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         flash_operation_control_reg <= `RST_FLASH_OP_CTRL;
      end else if (op_done && state_reg == ST_ERASE) begin
         flash_operation_control_reg <= `OP_IDLE;
      end else if (ctrl_write && unlocked) begin
         flash_operation_control_reg <= sfr_wdata_i[5:0];
      end
   end

   // Read back; the control register shows the live operation code.
   // Unmapped addresses and the key register read as zero.
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         sfr_rdata_o <= 8'h00;
      end else if (sfr_rd_i) begin
         case (sfr_addr_i)
            `ADDR_POWER_CONTROL:      sfr_rdata_o <= power_control_reg;
            `ADDR_FLASH_OP_CTRL:      sfr_rdata_o <= {2'b00, flash_operation_control_reg};
            `ADDR_FLASH_CLK_FLASH_CLOCK_MHZ_CODE:     sfr_rdata_o <= {3'b000, flash_clock_frequency_reg};
            `ADDR_FLASH_PROG_TIMING:  sfr_rdata_o <= flash_program_timing_reg;
            `ADDR_FLASH_ERASE_TIMING: sfr_rdata_o <= flash_erase_timing_reg;
            default:                  sfr_rdata_o <= 8'h00;
         endcase
      end
   end

   // Data-space writes pass through when program writes are disabled.
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         data_wr_o <= 1'b0;
      end else begin
         data_wr_o <= xmove_wr_i & ~program_write_enable;
      end
   end

   // Address and byte of the last external move, kept for the data-space write.
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         data_addr_o  <= 16'h0000;
         data_wdata_o <= 8'h00;
      end else if (xmove_wr_i) begin
         data_addr_o  <= xmove_addr;
         data_wdata_o <= acc_i;
      end
   end

   // Staging memory: even byte held, a paired odd byte completes the word.
   flash_stage_mem u_stage (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .wr_i      (stage_wr),
      .wr_odd_i  (xmove_addr[0]),
      .wr_data_i (acc_i),
      .word_o    (flash_wdata_o)
   );

   // Sequencer state choice.
   // Writes while busy are ignored; the core is stalled then anyway.
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (prog_wr) begin
               case (flash_operation_control_reg)
                  `OP_CHIP_ERASE:   state_next = ST_PREPROG;
                  `OP_SECTOR_ERASE: state_next = ST_PREPROG;
                  `OP_WORD_PROGRAM: begin
                     // An unpaired odd write is dropped.
                     if (odd_pairs) begin
                        state_next = ST_PROGRAM;
                     end
                  end
                  default:          state_next = ST_IDLE;
               endcase
            end
         end
         // Erase phases: the region is preprogrammed first, then erased.
         ST_PREPROG: if (op_done) state_next = ST_ERASE;
         ST_ERASE:   if (op_done) state_next = ST_IDLE;
         ST_PROGRAM: if (op_done) state_next = ST_IDLE;
         default:    state_next = ST_IDLE;
      endcase
   end

   // Sequencer state and the phase requests to the macro.
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         state_reg       <= ST_IDLE;
         flash_preprog_o <= 1'b0;
         flash_erase_o   <= 1'b0;
         flash_program_o <= 1'b0;
      end else begin
         state_reg       <= state_next;
         flash_preprog_o <= (state_next == ST_PREPROG);
         flash_erase_o   <= (state_next == ST_ERASE);
         flash_program_o <= (state_next == ST_PROGRAM);
      end
   end

   // Target of the macro operation and the held even byte of a word.
   // The odd write of a pair points the macro at the word's even address.
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         even_held_reg <= 1'b0;
         even_addr_reg <= 16'h0000;
         flash_addr_o  <= 16'h0000;
         flash_chip_o  <= 1'b0;
      end else begin
         if (phase_start) begin
            flash_addr_o <= xmove_addr;
            flash_chip_o <= chip_mode;
         end
         if (stage_wr) begin
            if (!xmove_addr[0]) begin
               even_held_reg <= 1'b1;
               even_addr_reg <= xmove_addr;
            end else begin
               even_held_reg <= 1'b0;
               flash_addr_o  <= even_addr_reg;
            end
         end
      end
   end
endmodule // program_flash_write_erase_control
`default_nettype wire

// ===== inc/flash_ctl_consts.vh
// Constants for the program flash write and erase controller.
`ifndef FLASH_CTL_CONSTS_VH
`define FLASH_CTL_CONSTS_VH
`define ADDR_POWER_CONTROL      8'h87
`define ADDR_FLASH_OP_CTRL      8'h9a
`define ADDR_FLASH_CLK_FLASH_CLOCK_MHZ_CODE     8'h9b
`define ADDR_FLASH_PROG_TIMING  8'h9c
`define ADDR_FLASH_ERASE_TIMING 8'h9d
`define ADDR_TIMED_ACCESS_KEY   8'hc7
`define KEY_FIRST               8'haa
`define KEY_SECOND              8'h55
`define OP_IDLE                 6'h00
`define OP_WORD_PROGRAM         6'h01
`define OP_SECTOR_ERASE         6'h02
`define OP_CHIP_ERASE           6'h04
`define PWE_BIT                 4
`define FLASH_CLOCK_MHZ_CODE_MSB                4
`define RST_POWER_CONTROL       8'h00
`define RST_FLASH_OP_CTRL       6'h00
`define RST_FLASH_CLK_FLASH_CLOCK_MHZ_CODE      5'h14
`define RST_FLASH_PROG_TIMING   8'h00
`define RST_FLASH_ERASE_TIMING  8'h00
`define SECTOR_ADDR_LSB         7
`define NEUTRAL_BYTE            8'h00
`endif

// ===== src/flash_stage_mem.v
// Two-byte staging memory holding the even and odd byte of a program word.
`timescale 1ns/1ps
`default_nettype none
module flash_stage_mem (
   // Clock and reset
   input  wire        ref_clk_i,
   input  wire        rst_i,
   // Write port
   input  wire        wr_i,
   input  wire        wr_odd_i,
   input  wire [7:0]  wr_data_i,
   // Read port
   output reg  [15:0] word_o
);
   reg [7:0] even_reg;
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         even_reg <= 8'h00;
         word_o   <= 16'h0000;
      end else if (wr_i) begin
         if (wr_odd_i) begin
            word_o <= {wr_data_i, even_reg};
         end else begin
            even_reg <= wr_data_i;
         end
      end
   end
endmodule // flash_stage_mem
`default_nettype wire

// ===== tb/flash_ctl_checker.sv
// Assertion checker for the flash write and erase controller.
`timescale 1ns/1ps
`default_nettype none
module flash_ctl_checker (
   input wire logic        ref_clk_i,
   input wire logic        rst_i,
   input wire logic        sfr_wr_i,
   input wire logic [7:0]  sfr_addr_i,
   input wire logic [7:0]  sfr_wdata_i,
   input wire logic        xmove_wr_i,
   input wire logic        xmove_ind_i,
   input wire logic [15:0] data_pointer_i,
   input wire logic [7:0]  port2_latch_i,
   input wire logic [7:0]  index_reg_i,
   input wire logic [7:0]  acc_i,
   input wire logic        flash_busy_stall_o,
   input wire logic        data_wr_o,
   input wire logic [15:0] data_addr_o,
   input wire logic [7:0]  data_wdata_o,
   input wire logic        flash_preprog_o,
   input wire logic        flash_erase_o,
   input wire logic        flash_program_o,
   input wire logic [4:0]  flash_clock_mhz_code_o,
   input wire logic        flash_done_i
);
   logic pwe_reg;
   logic pp_reg;
   // Mirrors the write enable bit and whether a preprogram phase ran in this busy spell.
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         pwe_reg <= 1'b0;
         pp_reg <= 1'b0;
      end else begin
         if (sfr_wr_i && sfr_addr_i == 8'h87) pwe_reg <= sfr_wdata_i[4];
         if (flash_preprog_o) pp_reg <= 1'b1;
         else if (!flash_busy_stall_o) pp_reg <= 1'b0;
      end
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   chk_phase_busy: assert property (
      (flash_preprog_o || flash_erase_o || flash_program_o) |-> flash_busy_stall_o)
      else $error("phase without busy");
   chk_preprog_first: assert property (
      flash_erase_o |-> pp_reg) else $error("erase without preprogram");
   chk_flash_clock_mhz_code_reset: assert property (disable iff (1'b0)
      rst_i |=> flash_clock_mhz_code_o == 5'h14) else $error("bad clock code reset");
   chk_ptr_write: assert property (
      xmove_wr_i && !xmove_ind_i && !pwe_reg && !flash_busy_stall_o |=> data_wr_o
      && data_addr_o == $past(data_pointer_i) && data_wdata_o == $past(acc_i))
      else $error("pointer data write wrong");
   chk_ind_addr: assert property (
      xmove_wr_i && xmove_ind_i && !pwe_reg && !flash_busy_stall_o |=> data_wr_o
      && data_addr_o == {$past(port2_latch_i), $past(index_reg_i)})
      else $error("indirect address wrong");
   chk_pwe_block: assert property (
      xmove_wr_i && pwe_reg |=> !data_wr_o) else $error("data write with enable set");
   chk_word_end: assert property (
      flash_program_o && flash_done_i |-> ##[1:5] !flash_busy_stall_o)
      else $error("busy stuck after word");
   chk_busy_cause: assert property (
      $rose(flash_busy_stall_o) |-> $past(xmove_wr_i)) else $error("busy without write");
endmodule // flash_ctl_checker
bind program_flash_write_erase_control flash_ctl_checker flash_ctl_checker_inst (.*);
`default_nettype wire

// ===== tb/flash_macro_model.sv
// Behavioural flash macro that ends each phase with a one-cycle done pulse.
`timescale 1ns/1ps
`default_nettype none
module flash_macro_model #(parameter int LAT = 5) (
   // Clock and reset
   input  wire logic ref_clk_i,
   input  wire logic rst_i,
   // Phase requests and completion
   input  wire logic preprog_i,
   input  wire logic erase_i,
   input  wire logic program_i,
   output var  logic done_o
);
   logic [2:0] ph_reg;
   int         cnt;
   // One done pulse per phase, LAT+1 cycles after the phase request rises.
   always @(posedge ref_clk_i) begin
      ph_reg <= {preprog_i, erase_i, program_i};
      done_o <= 1'b0;
      if (rst_i) cnt <= 0;
      else if ({preprog_i, erase_i, program_i} != ph_reg)
         cnt <= (preprog_i | erase_i | program_i) ? LAT : 0;
      else if (cnt > 1) cnt <= cnt - 1;
      else if (cnt == 1) begin
         cnt <= 0;
         done_o <= 1'b1;
      end
   end
endmodule // flash_macro_model
`default_nettype wire

// ===== tb/program_flash_write_erase_control_test.sv
// Self-checking testbench for the flash write and erase controller.
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctl_consts.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
   $display("Error t=%0t got %h exp %h", $time, g, e); end end
module program_flash_write_erase_control_test;
   logic        ref_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, xmove_wr_i = 1'b0, xmove_ind_i = 1'b0;
   logic [7:0]  sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, port2_latch_i = 8'h00;
   logic [7:0]  index_reg_i = 8'h00, acc_i = 8'h00;
   logic [15:0] data_pointer_i = 16'h0000;
   wire  [7:0]  sfr_rdata_o, data_wdata_o, flash_prog_timing_o, flash_erase_timing_o;
   wire  [15:0] data_addr_o, flash_addr_o, flash_wdata_o;
   wire  [4:0]  flash_clock_mhz_code_o;
   wire         flash_busy_stall_o, data_wr_o, flash_preprog_o, flash_erase_o;
   wire         flash_chip_o, flash_program_o, flash_done_i;
   int          errors = 0, num_checks = 0, cyc = 0;
   always #20 ref_clk_i = ~ref_clk_i;
   program_flash_write_erase_control program_flash_write_erase_control_inst (.*);
   flash_macro_model flash_macro_model_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .preprog_i(flash_preprog_o), .erase_i(flash_erase_o), .program_i(flash_program_o),
      .done_o(flash_done_i));
   task automatic sw(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      sfr_addr_i <= a;
      sfr_wdata_i <= d;
      sfr_wr_i <= 1'b1;
      @(posedge ref_clk_i);
      sfr_wr_i <= 1'b0;
   endtask
   task automatic sr(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk_i);
      sfr_addr_i <= a;
      sfr_rd_i <= 1'b1;
      @(posedge ref_clk_i);
      sfr_rd_i <= 1'b0;
      @(negedge ref_clk_i);
      `CHK(sfr_rdata_o, e)
   endtask
   // Interrupts stay off in this bench, so nothing splits the key writes.
   task automatic ul(input logic [7:0] v);
      sw(`ADDR_TIMED_ACCESS_KEY, 8'haa);
      sw(`ADDR_TIMED_ACCESS_KEY, 8'h55);
      sw(8'h9a, v);
   endtask
   task automatic xm(input logic ind, input logic [15:0] ad, input logic [7:0] d);
      @(posedge ref_clk_i);
      xmove_ind_i <= ind;
      data_pointer_i <= ad;
      port2_latch_i <= ad[15:8];
      index_reg_i <= ad[7:0];
      acc_i <= d;
      xmove_wr_i <= 1'b1;
      @(posedge ref_clk_i);
      xmove_wr_i <= 1'b0;
      @(negedge ref_clk_i);
   endtask
   task automatic wi;
      int n;
      n = 0;
      while (flash_busy_stall_o !== 1'b0 && n < 200) begin
         @(negedge ref_clk_i);
         n++;
      end
      `CHK(flash_busy_stall_o, 1'b0)
   endtask
   task automatic t_regs;
      sr(8'h87, 8'h00);
      sr(8'h9a, 8'h00);
      sr(8'h9b, 8'h14);
      sr(8'h9c, 8'h00);
      sr(8'h9d, 8'h00);
      sr(8'h90, 8'h00);
      sw(8'h9b, 8'h0a);
      sr(8'h9b, 8'h0a);
      `CHK(flash_clock_mhz_code_o, 5'h0a)
      sw(8'h9c, 8'h5a);
      sw(8'h9d, 8'ha5);
      sr(8'h9c, 8'h5a);
      `CHK(flash_prog_timing_o, 8'h5a)
      `CHK(flash_erase_timing_o, 8'ha5)
      $display("test regs done");
   endtask
   task automatic t_lock;
      sw(8'h9a, 8'h04);
      sr(8'h9a, 8'h00);
      sw(`ADDR_TIMED_ACCESS_KEY, 8'haa);
      sw(`ADDR_TIMED_ACCESS_KEY, 8'h55);
      sr(8'h87, 8'h00);
      sw(8'h9a, 8'h04);
      sr(8'h9a, 8'h00);
      ul(8'h02);
      sw(8'h9a, 8'h04);
      sr(8'h9a, 8'h02);
      ul(8'h00);
      $display("test lock done");
   endtask
   task automatic t_erase(input logic [5:0] op, input logic [15:0] ad);
      ul({2'b00, op});
      sw(8'h87, 8'h10);
      xm(1'b0, ad, 8'hff);
      `CHK(flash_busy_stall_o, 1'b1)
      `CHK(flash_chip_o, op == `OP_CHIP_ERASE)
      `CHK(flash_addr_o, ad)
      wi;
      sr(8'h9a, 8'h00);
      $display("test erase %h done", op);
   endtask
   task automatic t_prog;
      ul(8'h01);
      sw(8'h87, 8'h10);
      xm(1'b0, 16'h0102, 8'h3c);
      `CHK(flash_busy_stall_o, 1'b0)
      `CHK(data_wr_o, 1'b0)
      xm(1'b1, 16'h0103, 8'ha5);
      `CHK(flash_busy_stall_o, 1'b1)
      `CHK(flash_wdata_o, 16'ha53c)
      `CHK(flash_addr_o, 16'h0102)
      wi;
      sr(8'h9a, 8'h01);
      xm(1'b0, 16'h0105, 8'h0f);
      `CHK(flash_busy_stall_o, 1'b0)
      `CHK(flash_wdata_o, 16'ha53c)
      ul(8'h00);
      sr(8'h9a, 8'h00);
      sw(8'h87, 8'h00);
      xm(1'b0, 16'h1234, 8'h77);
      `CHK(data_addr_o, 16'h1234)
      `CHK(data_wr_o, 1'b1)
      xm(1'b1, 16'habcd, 8'h11);
      `CHK(data_addr_o, 16'habcd)
      $display("test program done");
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         report_and_stop;
      end
   end
   initial begin
      repeat (6) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      t_regs;
      t_lock;
      t_erase(`OP_CHIP_ERASE, 16'h2345);
      t_erase(`OP_SECTOR_ERASE, 16'h0180);
      t_prog;
      report_and_stop;
   end
endmodule // program_flash_write_erase_control_test
`default_nettype wire
